// ---- rtl/mpc_core.sv ----
// Microprogrammed 16-bit processor core: datapath, stack and control sequencer
// Function
// - Datapath works on 16-bit words with parallel binary arithmetic.
// - Seven 16-bit registers: program counter, data, address, four working registers.
// - Each microcycle the ALU takes any two registers and writes one back.
// - Sixteen-entry stack: pop onto A operand and/or push result, same microcycle.
// - Memory address is 16 bits from the address holding register.
// - Conditional branch picks one of sixteen conditions to decide the branch.
// - Conditions include result zero, result sign and an interrupt request.
// - Sixteen flags set or cleared by microcode; flags 0 and 1 request memory.
// - Fetch routine loads instruction's nine top bits as microcode start address.
// - Last fetch step branches the sequencer to that start address.
// - One microinstruction per microcycle of eight intervals.
// - Addressed flag set in second interval, cleared in sixth.
// - Branch condition sampled in the second interval.
// - Datapath built from four parallel 4-bit register-and-ALU slices.
`timescale 1ns/10ps
module mpc_core (
    input wire logic sys_clk_i, // 250 MHz clock
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic clk_en_i, // Freezes all state when low
    input wire logic [mpc_pkg::MPC_WORD_W-1:0] mem_rdata_i, // Memory read data
    input wire logic irq_i, // External interrupt request
    input wire logic [mpc_pkg::MPC_EXT_COND_W-1:0] ext_cond_i, // Spare branch conditions
    output logic [mpc_pkg::MPC_WORD_W-1:0] mem_addr_o, // Memory word address
    output logic [mpc_pkg::MPC_WORD_W-1:0] mem_wdata_o, // Memory write data
    output logic mem_rd_o, // Memory read request flag
    output logic mem_wr_o, // Memory write request flag
    output logic [mpc_pkg::MPC_NUM_FLAGS-1:0] flags_o, // All flag flip-flops
    output logic [2:0] interval_o, // Current interval, 0 is T1
    output logic [mpc_pkg::MPC_UADDR_W-1:0] upc_o // Current control address
);
    import mpc_pkg::*;

    typedef struct packed {
        logic [2:0] phase;
        logic [MPC_UADDR_W-1:0] upc;
        logic cond;
        logic [MPC_NUM_FLAGS-1:0] flags;
        logic [MPC_NUM_REGS-1:0][MPC_WORD_W-1:0] gpr;
        logic [MPC_STACK_DEPTH-1:0][MPC_WORD_W-1:0] stack;
        logic [3:0] sp;
        logic [MPC_WORD_W-1:0] result;
        logic carry;
        logic [MPC_WORD_W-1:0] mem_data;
        logic [MPC_WORD_W-1:0] rdata_s1;
        logic [MPC_WORD_W-1:0] rdata_s2;
        logic [MPC_EXT_COND_W:0] cin_s1;
        logic [MPC_EXT_COND_W:0] cin_s2;
    } mpc_state_t;

    mpc_state_t st_reg;
    mpc_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Control ROM: fetch routine at the bottom, every other word returns to fetch

    function automatic logic [MPC_UWORD_W-1:0] mpc_urom(input logic [MPC_UADDR_W-1:0] a);
        logic [MPC_UWORD_W-1:0] w;
        w = '0;
        case (a)
            9'h000: begin
                // Address register takes the program counter
                w[MPC_F_ASEL +: 3] = MPC_SEL_PC;
                w[MPC_F_DSEL +: 3] = MPC_SEL_MAR;
                w[MPC_F_OP +: 3] = MPC_OP_PASSA;
            end
            9'h001: begin
                // Read pulse on the read flag; read data captured at T7, data register loads at T8
                w[MPC_F_DSEL +: 3] = MPC_SEL_MDR;
                w[MPC_F_SRCMEM] = 1'b1;
                w[MPC_F_FADDR +: 4] = 4'(MPC_FLAG_MEM_RD);
                w[MPC_F_FSET] = 1'b1;
                w[MPC_F_FCLR] = 1'b1;
            end
            9'h002: begin
                // Advance program counter and dispatch on the instruction
                w[MPC_F_ASEL +: 3] = MPC_SEL_PC;
                w[MPC_F_DSEL +: 3] = MPC_SEL_PC;
                w[MPC_F_OP +: 3] = MPC_OP_INCA;
                w[MPC_F_SEQ +: 2] = MPC_SEQ_DISPATCH;
            end
            default: begin
                w[MPC_F_SEQ +: 2] = MPC_SEQ_JUMP;
                w[MPC_F_TGT +: MPC_UADDR_W] = MPC_FETCH_ADDR;
            end
        endcase
        return w;
    endfunction : mpc_urom

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath helpers

    function automatic logic [MPC_WORD_W-1:0] mpc_rd_reg(
        input logic [MPC_NUM_REGS-1:0][MPC_WORD_W-1:0] gpr,
        input logic [2:0] sel
    );
        logic [2:0] idx;
        idx = sel - 3'h1;
        return (sel == MPC_SEL_NONE) ? MPC_WORD_RST : gpr[idx];
    endfunction : mpc_rd_reg

    // One 4-bit register-and-ALU slice; carry ripples to the next slice
    function automatic logic [MPC_SLICE_W:0] mpc_slice(
        input logic [2:0] op,
        input logic [MPC_SLICE_W-1:0] a,
        input logic [MPC_SLICE_W-1:0] b,
        input logic ci
    );
        logic [MPC_SLICE_W:0] s;
        s = '0;
        case (op)
            MPC_OP_ADD: s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
            MPC_OP_SUB: s = {1'b0, a} + {1'b0, ~b} + {4'h0, ci};
            MPC_OP_INCA: s = {1'b0, a} + {4'h0, ci};
            MPC_OP_AND: s = {1'b0, a & b};
            MPC_OP_OR: s = {1'b0, a | b};
            MPC_OP_XOR: s = {1'b0, a ^ b};
            MPC_OP_PASSA: s = {1'b0, a};
            MPC_OP_PASSB: s = {1'b0, b};
            default: s = '0;
        endcase
        return s;
    endfunction : mpc_slice

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic [MPC_UWORD_W-1:0] uword;
    logic [2:0] a_sel;
    logic [2:0] b_sel;
    logic [2:0] d_sel;
    logic [2:0] op;
    logic [3:0] faddr;
    mpc_seq_t seq;
    logic [MPC_WORD_W-1:0] opnd_a;
    logic [MPC_WORD_W-1:0] opnd_b;
    logic [MPC_WORD_W-1:0] alu_r;
    logic [MPC_WORD_W-1:0] wb_data;
    logic alu_c;
    logic [MPC_NUM_COND-1:0] cond_vec;
    logic [3:0] sp_top;
    logic do_pop;
    logic do_push;

    always_comb begin
        st_next = st_reg;
        uword = mpc_urom(st_reg.upc);
        a_sel = uword[MPC_F_ASEL +: 3];
        b_sel = uword[MPC_F_BSEL +: 3];
        d_sel = uword[MPC_F_DSEL +: 3];
        op = uword[MPC_F_OP +: 3];
        faddr = uword[MPC_F_FADDR +: 4];
        seq = mpc_seq_t'(uword[MPC_F_SEQ +: 2]);
        sp_top = st_reg.sp - 4'h1;
        do_pop = (a_sel == MPC_SEL_NONE) && uword[MPC_F_POP];
        do_push = uword[MPC_F_PUSH];

        // Zero A selector yields stack top when popping, else zero
        opnd_a = do_pop ? st_reg.stack[sp_top] : mpc_rd_reg(st_reg.gpr, a_sel);
        opnd_b = mpc_rd_reg(st_reg.gpr, b_sel);

        // Four slices in parallel with rippled carry
        alu_c = (op == MPC_OP_SUB) || (op == MPC_OP_INCA);
        alu_r = '0;
        for (int i = 0; i < MPC_NUM_SLICES; i++) begin
            {alu_c, alu_r[i*MPC_SLICE_W +: MPC_SLICE_W]} = mpc_slice(op,
                opnd_a[i*MPC_SLICE_W +: MPC_SLICE_W],
                opnd_b[i*MPC_SLICE_W +: MPC_SLICE_W], alu_c);
        end
        wb_data = uword[MPC_F_SRCMEM] ? st_reg.mem_data : alu_r;

        // Zero, sign and carry conditions test the result of the previous microcycle
        cond_vec = '0;
        cond_vec[MPC_COND_ZERO] = (st_reg.result == MPC_WORD_RST);
        cond_vec[MPC_COND_SIGN] = st_reg.result[MPC_WORD_W-1];
        cond_vec[MPC_COND_CARRY] = st_reg.carry;
        cond_vec[MPC_COND_IRQ] = st_reg.cin_s2[MPC_EXT_COND_W];
        cond_vec[MPC_COND_TRUE] = 1'b1;
        cond_vec[MPC_NUM_COND-1:MPC_COND_EXT0] = st_reg.cin_s2[MPC_EXT_COND_W-1:0];

        // Input synchronisers
        st_next.rdata_s1 = mem_rdata_i;
        st_next.rdata_s2 = st_reg.rdata_s1;
        st_next.cin_s1 = {irq_i, ext_cond_i};
        st_next.cin_s2 = st_reg.cin_s1;

        st_next.phase = st_reg.phase + 3'h1;
        case (st_reg.phase)
            MPC_T2: begin
                st_next.cond = cond_vec[faddr];
                if (uword[MPC_F_FSET]) begin
                    st_next.flags[faddr] = 1'b1;
                end
            end
            MPC_T6: begin
                if (uword[MPC_F_FCLR]) begin
                    st_next.flags[faddr] = 1'b0;
                end
            end
            MPC_T7: begin
                st_next.mem_data = st_reg.rdata_s2;
            end
            MPC_T8: begin
                // Write-back, stack and sequencing all commit at the cycle end
                if (d_sel != MPC_SEL_NONE) begin
                    st_next.gpr[d_sel - 3'h1] = wb_data;
                end
                st_next.result = wb_data;
                st_next.carry = alu_c;
                // Pop and push together overwrite the top entry
                if (do_pop && do_push) begin
                    st_next.stack[sp_top] = wb_data;
                end else if (do_pop) begin
                    st_next.sp = sp_top;
                end else if (do_push) begin
                    st_next.stack[st_reg.sp] = wb_data;
                    st_next.sp = st_reg.sp + 4'h1;
                end
                case (seq)
                    MPC_SEQ_NEXT: st_next.upc = st_reg.upc + 9'h001;
                    MPC_SEQ_COND: st_next.upc = st_reg.cond ?
                        uword[MPC_F_TGT +: MPC_UADDR_W] : st_reg.upc + 9'h001;
                    MPC_SEQ_DISPATCH: st_next.upc =
                        st_reg.gpr[MPC_SEL_MDR - 3'h1][MPC_DISPATCH_LSB +: MPC_UADDR_W];
                    MPC_SEQ_JUMP: st_next.upc = uword[MPC_F_TGT +: MPC_UADDR_W];
                    default: st_next.upc = st_reg.upc + 9'h001;
                endcase
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    // Memory address always comes from the address holding register
    assign mem_addr_o = st_reg.gpr[MPC_SEL_MAR - 3'h1];
    assign mem_wdata_o = st_reg.gpr[MPC_SEL_MDR - 3'h1];
    assign mem_rd_o = st_reg.flags[MPC_FLAG_MEM_RD];
    assign mem_wr_o = st_reg.flags[MPC_FLAG_MEM_WR];
    assign flags_o = st_reg.flags;
    assign interval_o = st_reg.phase;
    assign upc_o = st_reg.upc;

endmodule : mpc_core

// ---- rtl/mpc_pkg.sv ----
// Shared constants and types for the microprogrammed processor core
package mpc_pkg;

    localparam int MPC_WORD_W = 16;
    localparam int MPC_NUM_REGS = 7;
    localparam int MPC_STACK_DEPTH = 16;
    localparam int MPC_UADDR_W = 9;
    localparam int MPC_UWORD_W = 32;
    localparam int MPC_SLICE_W = 4;
    localparam int MPC_NUM_SLICES = 4;
    localparam int MPC_NUM_COND = 16;
    localparam int MPC_NUM_FLAGS = 16;
    localparam int MPC_EXT_COND_W = 11;
    localparam int MPC_DISPATCH_LSB = 7;

    // Microcycle interval indices (T1 is 0)
    localparam logic [2:0] MPC_T1 = 3'h0;
    localparam logic [2:0] MPC_T2 = 3'h1;
    localparam logic [2:0] MPC_T6 = 3'h5;
    localparam logic [2:0] MPC_T7 = 3'h6;
    localparam logic [2:0] MPC_T8 = 3'h7;

    // Register selector codes; zero selects stack or constant zero
    localparam logic [2:0] MPC_SEL_NONE = 3'h0;
    localparam logic [2:0] MPC_SEL_PC = 3'h1;
    localparam logic [2:0] MPC_SEL_MDR = 3'h2;
    localparam logic [2:0] MPC_SEL_MAR = 3'h3;
    localparam logic [2:0] MPC_SEL_W0 = 3'h4;

    // Microword field positions
    localparam int MPC_F_ASEL = 29;
    localparam int MPC_F_BSEL = 26;
    localparam int MPC_F_DSEL = 23;
    localparam int MPC_F_OP = 20;
    localparam int MPC_F_POP = 19;
    localparam int MPC_F_PUSH = 18;
    localparam int MPC_F_SRCMEM = 17;
    localparam int MPC_F_FADDR = 13;
    localparam int MPC_F_FSET = 12;
    localparam int MPC_F_FCLR = 11;
    localparam int MPC_F_SEQ = 9;
    localparam int MPC_F_TGT = 0;

    // Dedicated flags
    localparam int MPC_FLAG_MEM_RD = 0;
    localparam int MPC_FLAG_MEM_WR = 1;

    // Condition inputs
    localparam int MPC_COND_ZERO = 0;
    localparam int MPC_COND_SIGN = 1;
    localparam int MPC_COND_CARRY = 2;
    localparam int MPC_COND_IRQ = 3;
    localparam int MPC_COND_TRUE = 4;
    localparam int MPC_COND_EXT0 = 5;

    // Reset values
    localparam logic [MPC_UADDR_W-1:0] MPC_FETCH_ADDR = 9'h000;
    localparam logic [MPC_WORD_W-1:0] MPC_WORD_RST = 16'h0000;
    localparam logic [3:0] MPC_SP_RST = 4'h0;

    typedef enum logic [2:0] {
        MPC_OP_ADD = 3'b000,
        MPC_OP_SUB = 3'b001,
        MPC_OP_AND = 3'b010,
        MPC_OP_OR = 3'b011,
        MPC_OP_XOR = 3'b100,
        MPC_OP_PASSA = 3'b101,
        MPC_OP_PASSB = 3'b110,
        MPC_OP_INCA = 3'b111
    } mpc_op_t;

    typedef enum logic [1:0] {
        MPC_SEQ_NEXT = 2'b00,
        MPC_SEQ_COND = 2'b01,
        MPC_SEQ_DISPATCH = 2'b10,
        MPC_SEQ_JUMP = 2'b11
    } mpc_seq_t;

endpackage : mpc_pkg

// ---- bench/mpc_core_monitor.sv ----
// Port-level property checker for the processor core
`timescale 1ns/10ps
module mpc_core_monitor (
    input wire logic sys_clk_i, // Clock
    input wire logic sys_rst_i, // Async reset
    input wire logic clk_en_i, // Clock enable
    input wire logic [15:0] mem_addr_o, // Memory address
    input wire logic [15:0] mem_wdata_o, // Data holding register
    input wire logic mem_rd_o, // Read request
    input wire logic [15:0] flags_o, // Flag flops
    input wire logic [2:0] interval_o, // Current interval
    input wire logic [8:0] upc_o // Control address
);
    logic [8:0] disp_tgt;
    logic rst_hold_reg;
    assign disp_tgt = mem_wdata_o[15:7];
    // Masks the release edge too, where $past still sees reset values
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_hold_reg <= 1'b1;
        end else begin
            rst_hold_reg <= 1'b0;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i || rst_hold_reg);
    ////////////////////////////////////////////////////////////
    a_interval_step: assert property (
        clk_en_i |=> interval_o == $past(interval_o) + 3'h1) else $error("interval skipped");
    a_frozen_state: assert property (
        !clk_en_i |=> $stable(upc_o) && $stable(flags_o) && $stable(mem_addr_o))
        else $error("state moved while disabled");
    a_read_rise: assert property (
        $rose(mem_rd_o) |-> interval_o == 3'h2 && upc_o == 9'h001) else $error("late read set");
    a_read_fall: assert property (
        $fell(mem_rd_o) |-> interval_o == 3'h6) else $error("read clear off interval six");
    a_flag_edges: assert property (
        $changed(flags_o) |-> interval_o inside {3'h2, 3'h6}) else $error("flag moved off time");
    a_upc_at_t8: assert property (
        $changed(upc_o) |-> interval_o == 3'h0 && $past(interval_o) == 3'h7)
        else $error("control address moved mid cycle");
    a_seq_step: assert property (
        upc_o == 9'h000 && interval_o == 3'h7 && clk_en_i |=> upc_o == 9'h001)
        else $error("no sequential step");
    a_dispatch_target: assert property (
        upc_o == 9'h002 && interval_o == 3'h7 && clk_en_i |=> upc_o == $past(disp_tgt))
        else $error("wrong dispatch target");
    a_addr_held: assert property (
        mem_rd_o |-> $stable(mem_addr_o)) else $error("address moved during read");
    c_dispatch: cover property (upc_o == 9'h002 && interval_o == 3'h7 && clk_en_i);
    c_stall_read: cover property (!clk_en_i && mem_rd_o);
    c_read: cover property ($rose(mem_rd_o));
endmodule : mpc_core_monitor
bind mpc_core mpc_core_monitor mon (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rd_o(mem_rd_o), .flags_o(flags_o), .interval_o(interval_o), .upc_o(upc_o));

// ---- bench/mpc_mem_model.sv ----
// Behavioural system memory answering reads, prompt or one cycle late
`timescale 1ns/10ps
module mpc_mem_model (
    input wire logic sys_clk_i, // Clock
    input wire logic mem_rd_i, // Read request
    input wire logic [15:0] mem_addr_i, // Word address
    input wire logic delay_i, // One extra cycle before data
    output logic [15:0] mem_rdata_o = 16'h0000 // Read data
);
    logic [15:0] mem [0:255];
    logic seen_reg = 1'b0;
    logic [1:0] tail_reg = 2'h0;
    // Released bus holds read data two more cycles, then toggles so stale data never passes as valid
    always @(posedge sys_clk_i) begin
        seen_reg <= mem_rd_i;
        tail_reg <= mem_rd_i ? 2'h2 : ((tail_reg == 2'h0) ? 2'h0 : tail_reg - 2'h1);
        if ((mem_rd_i && (seen_reg || !delay_i)) || (!mem_rd_i && tail_reg != 2'h0)) begin
            mem_rdata_o <= mem[mem_addr_i[7:0]];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : mpc_mem_model

// ---- bench/mpc_core_tb.sv ----
// Self-checking bench for instruction fetch and dispatch
`timescale 1ns/10ps
module mpc_core_tb;
    typedef struct {logic [15:0] addr; logic [15:0] data;} mpc_note_t;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic irq_i = 1'b0;
    logic [10:0] ext_cond_i = 11'h000;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, flags_o, w;
    logic mem_rd_o, mem_wr_o;
    logic [2:0] interval_o;
    logic [8:0] upc_o;
    logic [8:0] last_upc = 9'h000;
    logic [15:0] rd_addr = 16'h0000;
    logic [31:0] rnd;
    mpc_note_t notes[$];
    mpc_note_t n;
    int err_count = 0;
    int comparisons = 0;
    int seed = 84;
    int next_pc = 0;
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    mpc_core dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .mem_rdata_i(mem_rdata_i), .irq_i(irq_i), .ext_cond_i(ext_cond_i),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .flags_o(flags_o), .interval_o(interval_o), .upc_o(upc_o));
    mpc_mem_model mem_m (.sys_clk_i(sys_clk_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .delay_i(slow), .mem_rdata_o(mem_rdata_i));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        sys_rst_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check("reset state", {upc_o, interval_o, mem_rd_o, mem_wr_o, 2'h0}, 16'h0000);
        check("reset registers", mem_addr_o | mem_wdata_o | flags_o, 16'h0000);
        notes.delete();
        next_pc = 0;
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
    endtask : do_reset
    task automatic run_batch(input string name, input int count);
        int t;
        t = 0;
        for (int i = 0; i < count; i++) begin
            notes.push_back('{16'(next_pc), mem_m.mem[next_pc]});
            next_pc++;
        end
        while (notes.size() != 0 && t < 3000) begin
            @(posedge sys_clk_i);
            t++;
        end
        if (notes.size() != 0) err_count++;
        $display("%s finished", name);
    endtask : run_batch
    // Spare conditions and enable stalls are noise the fetch must ride through
    always @(posedge sys_clk_i) begin
        rnd = $random(seed);
        clk_en_i <= !stall || rnd[0];
        irq_i <= rnd[1];
        ext_cond_i <= rnd[12:2];
    end
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            last_upc <= 9'h000;
        end else begin
            last_upc <= upc_o;
            if (mem_rd_o === 1'b1) rd_addr <= mem_addr_o;
            if (last_upc == 9'h002 && upc_o != 9'h002 && notes.size() != 0) begin
                n = notes.pop_front();
                check("read address", rd_addr, n.addr);
                check("data register", mem_wdata_o, n.data);
                check("dispatch address", {7'h00, upc_o}, {7'h00, n.data[15:7]});
            end
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) begin
            w = 16'($random(seed));
            // Targets one and two would re-enter the fetch routine
            if (w[15:7] == 9'h001 || w[15:7] == 9'h002) w[15:7] = 9'h1FF;
            mem_m.mem[i] = w;
        end
        mem_m.mem[0][15:7] = 9'h000;
        mem_m.mem[1][15:7] = 9'h1FF;
        do_reset();
        run_batch("fast memory", 6);
        slow <= 1'b1;
        stall <= 1'b1;
        run_batch("slow memory with stalls", 6);
        repeat (12) @(posedge sys_clk_i);
        do_reset();
        run_batch("restart after reset", 4);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_count++;
        end_of_test();
    end
endmodule : mpc_core_tb
